// ==== comr_assertions.sv ====
// Port checker for the channel one map register bank
`timescale 1ns/1ps
`default_nettype none

module comr_assertions
    import comr_pkg::*;
(
    // All ports of the bank
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic [ADDR_W-1:0]      reg_addr,
    input wire logic [DATA_W-1:0]      reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [DATA_W-1:0]      reg_rdata,
    input wire logic                   convert_start,
    input wire logic                   convert_done,
    input wire logic                   channel_one_enable,
    input wire logic [SETUP_W-1:0]     channel_one_setup_select,
    input wire logic [SRC_W-1:0]       channel_one_positive_source,
    input wire logic [SRC_W-1:0]       channel_one_negative_source,
    input wire logic                   channel_one_busy,
    input wire logic [SETUP_COUNT-1:0] setup_group_select,
    input wire logic [ROUTE_W-1:0]     positive_route,
    input wire logic [ROUTE_W-1:0]     negative_route
);
    // ************************************************************
    // Port relations
    // ************************************************************
    logic [12:0] w_fields;

    // Field bits of the write word
    assign w_fields = {reg_wdata[15], reg_wdata[13:12], reg_wdata[9:0]};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == DATA_ZERO)
        else $error("read data not zero outside read cycle");
    unmapped_rd_a: assert property (reg_rd && reg_addr != CHANNEL_ONE_MAP_ADDR
        && reg_addr != STATUS_ADDR |=> reg_rdata == DATA_ZERO)
        else $error("unmapped read not zero");
    rsvd_read_a: assert property (reg_rd && reg_addr == CHANNEL_ONE_MAP_ADDR
        |=> (reg_rdata & RESERVED_MASK) == DATA_ZERO)
        else $error("reserved bits read nonzero");
    field_copy_a: assert property (reg_wr && reg_addr == CHANNEL_ONE_MAP_ADDR ##1 !reg_wr
        |=> {channel_one_enable, channel_one_setup_select, channel_one_positive_source,
        channel_one_negative_source} == $past(w_fields, 2))
        else $error("field outputs differ from written word");
    rst_load_a: assert property (disable iff (1'h0) rst |=> !channel_one_enable
        && channel_one_setup_select == 2'h0 && channel_one_positive_source == SRC_ANALOG_INPUT_ZERO
        && channel_one_negative_source == SRC_ANALOG_INPUT_ONE && !channel_one_busy)
        else $error("reset values wrong");
    busy_group_a: assert property (channel_one_busy |-> $onehot(setup_group_select))
        else $error("setup group not one-hot while busy");
    idle_off_a: assert property (!channel_one_busy |-> setup_group_select == 4'h0
        && positive_route == 7'h00 && negative_route == 7'h00)
        else $error("group or route active while idle");
    done_drop_a: assert property (channel_one_busy && convert_done |=> !channel_one_busy)
        else $error("busy stays after done");
    start_group_a: assert property (!channel_one_busy ##1 channel_one_busy
        && $stable(channel_one_setup_select)
        |-> setup_group_select == 4'h1 << channel_one_setup_select)
        else $error("setup group does not match select");

    // Main scenarios
    cover property (reg_wr && reg_addr == CHANNEL_ONE_MAP_ADDR);
    cover property (convert_start && channel_one_enable ##1 channel_one_busy);
    cover property (channel_one_busy && convert_done);
endmodule

bind comr_top comr_assertions i_chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .convert_start, .convert_done, .channel_one_enable, .channel_one_setup_select,
    .channel_one_positive_source, .channel_one_negative_source, .channel_one_busy,
    .setup_group_select, .positive_route, .negative_route);

`default_nettype wire

// ==== comr_map_store.sv ====
// Storage cell for the channel one map register with masked writes
`timescale 1ns/1ps
`default_nettype none

module comr_map_store
    import comr_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Write side
    input  wire logic              wr_en,
    input  wire logic [DATA_W-1:0] wr_data,
    // Stored value
    output logic      [DATA_W-1:0] value
);

    // Masked write; reserved bits always load zero
    always_ff @(posedge clk)
    begin
        if (rst)
            value <= CHANNEL_ONE_MAP_RESET;
        else if (wr_en)
            value <= wr_data & WRITABLE_MASK;
    end

endmodule

`default_nettype wire

// ==== comr_pkg.sv ====
// Constants, field layout and types for the channel one map register bank
package comr_pkg;

    // ************************************************************
    // Register bus and addresses
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam logic [ADDR_W-1:0] CHANNEL_ONE_MAP_ADDR = 8'h11;
    localparam logic [ADDR_W-1:0] STATUS_ADDR          = 8'h40;
    localparam logic [DATA_W-1:0] CHANNEL_ONE_MAP_RESET = 16'h0001;
    localparam logic [DATA_W-1:0] DATA_ZERO            = 16'h0000;

    // ************************************************************
    // Map register field layout
    // ************************************************************
    localparam int unsigned ENABLE_BIT  = 15;
    localparam int unsigned RSVD_TOP    = 14;
    localparam int unsigned SETUP_HI    = 13;
    localparam int unsigned SETUP_LO    = 12;
    localparam int unsigned RSVD_HI     = 11;
    localparam int unsigned RSVD_LO     = 10;
    localparam int unsigned POS_HI      = 9;
    localparam int unsigned POS_LO      = 5;
    localparam int unsigned NEG_HI      = 4;
    localparam int unsigned NEG_LO      = 0;
    localparam int unsigned SRC_W       = 5;
    localparam int unsigned SETUP_W     = 2;
    localparam int unsigned SETUP_COUNT = 4;
    // Bits software can change; reserved bits stay zero
    localparam logic [DATA_W-1:0] WRITABLE_MASK = 16'hB3FF;
    localparam logic [DATA_W-1:0] RESERVED_MASK = 16'h4C00;

    // ************************************************************
    // Input source codes and route positions
    // ************************************************************
    localparam logic [SRC_W-1:0] SRC_ANALOG_INPUT_ZERO    = 5'h00;
    localparam logic [SRC_W-1:0] SRC_ANALOG_INPUT_ONE    = 5'h01;
    localparam logic [SRC_W-1:0] SRC_ANALOG_INPUT_TWO    = 5'h02;
    localparam logic [SRC_W-1:0] SRC_ANALOG_INPUT_THREE    = 5'h03;
    localparam logic [SRC_W-1:0] SRC_ANALOG_INPUT_FOUR    = 5'h04;
    localparam logic [SRC_W-1:0] SRC_REF_POS = 5'h15;
    localparam logic [SRC_W-1:0] SRC_REF_NEG = 5'h16;
    localparam int unsigned ROUTE_W       = 7;
    localparam int unsigned ROUTE_REF_POS = 5;
    localparam int unsigned ROUTE_REF_NEG = 6;

    // ************************************************************
    // Status register layout
    // ************************************************************
    localparam int unsigned ST_ENABLE    = 0;
    localparam int unsigned ST_BUSY      = 1;
    localparam int unsigned ST_POS_BAD   = 2;
    localparam int unsigned ST_NEG_BAD   = 3;
    localparam int unsigned ST_WRITE_ERR = 4;
    localparam int unsigned ST_SETUP_LO  = 8;

    // Conversion phase of this channel
    typedef enum logic [0:0] {
        COMR_IDLE,
        COMR_CONVERTING
    } comr_state_e;

endpackage

// ==== comr_top.sv ====
// Channel one map register bank with input routing and setup selection
`timescale 1ns/1ps
`default_nettype none

module comr_top
    import comr_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Register port
    input  wire logic [ADDR_W-1:0]      reg_addr,
    input  wire logic [DATA_W-1:0]      reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [DATA_W-1:0]      reg_rdata,
    // Sequencer handshake
    input  wire logic                   convert_start,
    input  wire logic                   convert_done,
    // Register fields
    output logic                        channel_one_enable,
    output logic      [SETUP_W-1:0]     channel_one_setup_select,
    output logic      [SRC_W-1:0]       channel_one_positive_source,
    output logic      [SRC_W-1:0]       channel_one_negative_source,
    // Conversion controls
    output logic                        channel_one_busy,
    output logic      [SETUP_COUNT-1:0] setup_group_select,
    output logic      [ROUTE_W-1:0]     positive_route,
    output logic      [ROUTE_W-1:0]     negative_route
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Source code to one-hot switch pattern; unknown codes open all
    function automatic logic [ROUTE_W-1:0] source_route(input logic [SRC_W-1:0] code);
        logic [ROUTE_W-1:0] route;
        route = '0;
        unique case (code)
            SRC_ANALOG_INPUT_ZERO:    route[0] = 1'b1;
            SRC_ANALOG_INPUT_ONE:    route[1] = 1'b1;
            SRC_ANALOG_INPUT_TWO:    route[2] = 1'b1;
            SRC_ANALOG_INPUT_THREE:    route[3] = 1'b1;
            SRC_ANALOG_INPUT_FOUR:    route[4] = 1'b1;
            SRC_REF_POS: route[ROUTE_REF_POS] = 1'b1;
            SRC_REF_NEG: route[ROUTE_REF_NEG] = 1'b1;
            default:     route = '0;
        endcase
        return route;
    endfunction

    // True for a code that names a real source
    function automatic logic source_valid(input logic [SRC_W-1:0] code);
        return |source_route(code);
    endfunction

    // Setup number to one-hot group select
    function automatic logic [SETUP_COUNT-1:0] setup_onehot(input logic [SETUP_W-1:0] sel);
        logic [SETUP_COUNT-1:0] grp;
        grp = '0;
        grp[sel] = 1'b1;
        return grp;
    endfunction

    // ************************************************************
    // Address decode
    // ************************************************************

    logic              map_hit;
    logic              status_hit;
    logic              map_wr;
    logic              status_rd;
    logic [DATA_W-1:0] map_value;
    logic [SRC_W-1:0]  wr_pos_code;
    logic [SRC_W-1:0]  wr_neg_code;
    logic              wr_bad;

    // Register selects
    assign map_hit    = (reg_addr == CHANNEL_ONE_MAP_ADDR);
    assign status_hit = (reg_addr == STATUS_ADDR);
    assign map_wr     = reg_wr && map_hit;
    assign status_rd  = reg_rd && status_hit;

    // Write content checks
    assign wr_pos_code = reg_wdata[POS_HI:POS_LO];
    assign wr_neg_code = reg_wdata[NEG_HI:NEG_LO];
    assign wr_bad      = map_wr && (((reg_wdata & RESERVED_MASK) != DATA_ZERO)
                         || !source_valid(wr_pos_code)
                         || !source_valid(wr_neg_code));

    // ************************************************************
    // Map register storage
    // ************************************************************

    // Sixteen-bit map, reset 0x0001, reserved bits forced to zero
    comr_map_store u_store
    (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (map_wr),
        .wr_data (reg_wdata),
        .value   (map_value)
    );

    // Field views of the stored map
    logic                   map_enable;
    logic [SETUP_W-1:0]     map_setup;
    logic [SRC_W-1:0]       map_pos;
    logic [SRC_W-1:0]       map_neg;

    assign map_enable = map_value[ENABLE_BIT];
    assign map_setup  = map_value[SETUP_HI:SETUP_LO];
    assign map_pos    = map_value[POS_HI:POS_LO];
    assign map_neg    = map_value[NEG_HI:NEG_LO];

    // ************************************************************
    // Conversion state
    // ************************************************************

    comr_state_e state;
    comr_state_e next_state;
    logic        start_ok;

    // A start is taken only while the channel is enabled
    assign start_ok = convert_start && map_enable;

    // Next conversion phase
    always_comb
    begin
        next_state = state;
        unique case (state)
            COMR_IDLE:
            begin
                if (start_ok)
                    next_state = COMR_CONVERTING;
            end
            COMR_CONVERTING:
            begin
                if (convert_done || !map_enable)
                    next_state = COMR_IDLE;
            end
        endcase
    end

    // Phase register
    always_ff @(posedge clk)
    begin
        if (rst)
            state <= COMR_IDLE;
        else
            state <= next_state;
    end

    // ************************************************************
    // Conversion controls
    // ************************************************************

    logic converting_next;

    assign converting_next = (next_state == COMR_CONVERTING);

    // Busy flag follows the phase
    always_ff @(posedge clk)
    begin
        if (rst)
            channel_one_busy <= 1'b0;
        else
            channel_one_busy <= converting_next;
    end

    // Setup group and input switches, captured at conversion start
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            setup_group_select <= '0;
            positive_route     <= '0;
            negative_route     <= '0;
        end
        else if (!converting_next)
        begin
            setup_group_select <= '0;
            positive_route     <= '0;
            negative_route     <= '0;
        end
        else if (state == COMR_IDLE)
        begin
            setup_group_select <= setup_onehot(map_setup);
            positive_route     <= source_route(map_pos);
            negative_route     <= source_route(map_neg);
        end
    end

    // ************************************************************
    // Field outputs
    // ************************************************************

    // Registered copies of the live fields
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            channel_one_enable          <= CHANNEL_ONE_MAP_RESET[ENABLE_BIT];
            channel_one_setup_select    <= CHANNEL_ONE_MAP_RESET[SETUP_HI:SETUP_LO];
            channel_one_positive_source <= CHANNEL_ONE_MAP_RESET[POS_HI:POS_LO];
            channel_one_negative_source <= CHANNEL_ONE_MAP_RESET[NEG_HI:NEG_LO];
        end
        else
        begin
            channel_one_enable          <= map_enable;
            channel_one_setup_select    <= map_setup;
            channel_one_positive_source <= map_pos;
            channel_one_negative_source <= map_neg;
        end
    end

    // ************************************************************
    // Write error flag
    // ************************************************************

    logic write_err;

    // Sticky; a new error wins over the clear by status read
    always_ff @(posedge clk)
    begin
        if (rst)
            write_err <= 1'b0;
        else if (wr_bad)
            write_err <= 1'b1;
        else if (status_rd)
            write_err <= 1'b0;
    end

    // ************************************************************
    // Read path
    // ************************************************************

    logic [DATA_W-1:0] status_word;

    // Status view of the block's own state
    always_comb
    begin
        status_word                           = DATA_ZERO;
        status_word[ST_ENABLE]                = map_enable;
        status_word[ST_BUSY]                  = channel_one_busy;
        status_word[ST_POS_BAD]               = !source_valid(map_pos);
        status_word[ST_NEG_BAD]               = !source_valid(map_neg);
        status_word[ST_WRITE_ERR]             = write_err;
        status_word[ST_SETUP_LO+SETUP_W-1:ST_SETUP_LO] = map_setup;
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk)
    begin
        if (rst)
            reg_rdata <= DATA_ZERO;
        else if (reg_rd && map_hit)
            reg_rdata <= map_value;
        else if (status_rd)
            reg_rdata <= status_word;
        else
            reg_rdata <= DATA_ZERO;
    end

endmodule

`default_nettype wire

// ==== testbench.sv ====
// Self-checking testbench for the channel one map register bank
`timescale 1ns/1ps
`default_nettype none

module testbench
    import comr_pkg::*;
;
    // ************************************************************
    // Signals and rows
    // ************************************************************
    typedef struct packed {logic [15:0] w; logic [15:0] e; logic [6:0] pr; logic [6:0] nr;} comr_row_s;
    comr_row_s rows [7] = '{'{16'h8001, 16'h8001, 7'h01, 7'h02}, '{16'h9022, 16'h9022, 7'h02, 7'h04},
        '{16'hA043, 16'hA043, 7'h04, 7'h08}, '{16'hFC64, 16'hB064, 7'h08, 7'h10},
        '{16'h8095, 16'h8095, 7'h10, 7'h20}, '{16'h82B6, 16'h82B6, 7'h20, 7'h40},
        '{16'h82C0, 16'h82C0, 7'h40, 7'h01}};
    logic              clk = 1'h0;
    logic              rst = 1'h1;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 16'h0000;
    logic              reg_wr = 1'h0;
    logic              reg_rd = 1'h0;
    logic              convert_start = 1'h0;
    logic              convert_done = 1'h0;
    logic [DATA_W-1:0] reg_rdata, rv;
    logic              channel_one_enable, channel_one_busy;
    logic [1:0]        channel_one_setup_select;
    logic [4:0]        channel_one_positive_source, channel_one_negative_source;
    logic [3:0]        setup_group_select;
    logic [6:0]        positive_route, negative_route;
    int                n_mismatch = 0;
    int                num_checks = 0;
    int                cyc = 0;

    comr_top i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .convert_start, .convert_done, .channel_one_enable, .channel_one_setup_select,
        .channel_one_positive_source, .channel_one_negative_source, .channel_one_busy,
        .setup_group_select, .positive_route, .negative_route);

    // Clock and hang limit
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Bus cycles, entered right after a rising edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask

    task automatic chk_fields(input logic [15:0] e);
        @(negedge clk);
        chk("fields", {e[15], e[13:12], e[9:0]}, {channel_one_enable, channel_one_setup_select,
            channel_one_positive_source, channel_one_negative_source});
        @(posedge clk);
    endtask

    // Start, check routing, then end the conversion
    task automatic conv(input logic [15:0] e, input logic [6:0] p, input logic [6:0] n, input logic on);
        convert_start <= 1'h1;
        @(posedge clk);
        convert_start <= 1'h0;
        @(negedge clk);
        chk("busy", on, channel_one_busy);
        chk("group", on ? 4'h1 << e[13:12] : 4'h0, setup_group_select);
        chk("routes", {p, n}, {positive_route, negative_route});
        @(posedge clk);
        convert_done <= 1'h1;
        @(posedge clk);
        convert_done <= 1'h0;
        @(negedge clk);
        chk("end", 15'h0000, {channel_one_busy, positive_route, negative_route});
        @(posedge clk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        rd(CHANNEL_ONE_MAP_ADDR, rv);
        chk("reset map", CHANNEL_ONE_MAP_RESET, rv);
        chk_fields(CHANNEL_ONE_MAP_RESET);
        conv(CHANNEL_ONE_MAP_RESET, 7'h00, 7'h00, 1'h0);
        $display("reset test done");
        foreach (rows[i])
        begin
            wr(CHANNEL_ONE_MAP_ADDR, rows[i].w);
            rd(CHANNEL_ONE_MAP_ADDR, rv);
            chk("map", rows[i].e, rv);
            chk_fields(rows[i].e);
            conv(rows[i].e, rows[i].pr, rows[i].nr, 1'h1);
            $display("row %0d done", i);
        end
        rd(8'h20, rv);
        chk("unmapped read", DATA_ZERO, rv);
        wr(8'h20, 16'h0000);
        rd(CHANNEL_ONE_MAP_ADDR, rv);
        chk("unmapped write", 16'h82C0, rv);
        $display("address test done");
        rd(STATUS_ADDR, rv);
        chk("status", 16'h0011, rv);
        rd(STATUS_ADDR, rv);
        chk("status clear", 16'h0001, rv);
        wr(CHANNEL_ONE_MAP_ADDR, 16'h90B7);
        rd(STATUS_ADDR, rv);
        chk("bad codes", 16'h011D, rv);
        conv(16'h90B7, 7'h00, 7'h00, 1'h1);
        rd(STATUS_ADDR, rv);
        chk("status after", 16'h010D, rv);
        $display("status test done");
        convert_start <= 1'h1;
        @(posedge clk);
        convert_start <= 1'h0;
        wr(CHANNEL_ONE_MAP_ADDR, 16'h0001);
        repeat (2) @(negedge clk);
        chk("abort", 1'h0, channel_one_busy);
        @(posedge clk);
        $display("abort test done");
        wr(CHANNEL_ONE_MAP_ADDR, 16'hA043);
        rst <= 1'h1;
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        rd(CHANNEL_ONE_MAP_ADDR, rv);
        chk("second reset", CHANNEL_ONE_MAP_RESET, rv);
        $display("second reset test done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
